// *** src/fault_manager.sv ***
`timescale 1ns/1ps
// Overview of operation
// [R1] main supply undervoltage: power stage, pump, controller off, then reset
// [R2] analog regulator undervoltage: same shutdown and reset as main supply
// [R3] step-down feedback low: flag it, keep regulating, no shutdown
// [R4] pump low: stage off, fault pin low, driver and pump flags set
// [R5] pump low ends: resume alone; pump flag held until clear command
// [R6] supply overvoltage: stage off, fault pin low, driver and ov flags
// [R7] overvoltage ends: resume alone; ov flag held until clear command
// [R8] overvoltage enable at zero: overvoltage ignored completely
// [R9] one level select bit picks the low or high overvoltage trip
// [R10] probe ramp too long, enabled: report, stage off, timed retry
// [R11] probe pulse before decay, enabled: report, stage off, timed retry
// [R12] measurement probe timeout or weak back-emf: report, stage off, latch
// [R13] bus current over limit, enabled: report, limit speed, stage runs
// [R14] current loop saturation, enabled: report, stage runs, clears alone
// [R15] speed loop saturation, enabled: report, stage runs, clears alone
// [R16] missed watchdog: report; action bit picks run on or latched off
// [R17] retry: stage and fault pin restored after lock retry time
// [R18] latched faults end on clear command once the condition is gone
// [R19] host refreshes watchdog within interval while supervision enabled
// [R20] fault pin low while any reporting fault is active or latched
module fault_manager #(
  parameter int unsigned PROBE_TIMEOUT_CYC = fault_pkg::PROBE_TIMEOUT_CYCLES,
  parameter int unsigned RETRY_UNIT_CYC = fault_pkg::RETRY_UNIT_CYCLES,
  parameter int unsigned WDT_UNIT_CYC = fault_pkg::WDT_UNIT_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire fault_pkg::apb_req_t apb_req,
  output fault_pkg::apb_rsp_t apb_rsp,
  input wire fault_pkg::sense_t sense,
  output logic fault_out_n,
  output logic fets_off,
  output logic pump_enable,
  output logic ctrl_enable,
  output logic core_reset,
  output logic speed_limit
);
  import fault_pkg::*;

  function automatic logic reg_hit(input logic [ADDR_W-1:0] addr,
                                   input logic [ADDR_W-1:0] offset);
    reg_hit = (addr == offset);
  endfunction

  sense_t sync1_r;
  sense_t s;
  ctrl_cfg_t cfg_r;
  pwr_state_t state_r;
  apb_rsp_t rsp_r;
  status_t status;
  logic fault_out_n_r, fets_off_r, pump_enable_r, ctrl_enable_r;
  logic core_reset_r, speed_limit_r, fault_clear_cmd_r;
  logic pulse_prev_r, tickle_prev_r, probe_to_prev_r, wdt_prev_r;
  logic pump_low_flag_r, ov_flag_r, buck_flag_r;
  logic probe_to_flag_r, rate_flag_r;
  logic meas_probe_r, meas_bemf_r, wdt_flag_r, wdt_lock_r;
  logic uv_any, ov_trip, ov_live, probe_to, probe_to_rise;
  logic meas_probe_cond, bemf_cond, probe_to_evt, rate_evt, retry_evt;
  logic retry_done, wdt_expired, wdt_rise, tickle_rise;
  logic bus_live, cur_sat_live, spd_sat_live;
  logic drv_fault, ctrl_fault, any_report, hiz;
  logic access, commit, mapped;

  // pins from the analog side are asynchronous to ref_clk
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= '0;
      s <= '0;
    end else begin
      sync1_r <= sense;
      s <= sync1_r;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pulse_prev_r <= 1'b0;
      tickle_prev_r <= 1'b0;
      probe_to_prev_r <= 1'b0;
      wdt_prev_r <= 1'b0;
    end else begin
      pulse_prev_r <= s.probe_pulse;
      tickle_prev_r <= s.watchdog_tickle;
      probe_to_prev_r <= probe_to;
      wdt_prev_r <= wdt_expired;
    end
  end

  assign uv_any = s.supply_uv | s.avdd_uv; // see [R1] see [R2]
  assign ov_trip = cfg_r.supply_overvoltage_level_sel ?
                   s.supply_ov_high_trip : s.supply_ov_low_trip; // see [R9]
  assign ov_live = cfg_r.supply_overvoltage_enable & ov_trip; // see [R8]
  assign probe_to_rise = probe_to & !probe_to_prev_r;
  assign meas_probe_cond = probe_to & s.measure_rl; // see [R12]
  assign bemf_cond = s.measure_ke & s.backemf_low; // see [R12]
  // a timeout while measure_rl is set latches instead of retrying
  assign probe_to_evt = probe_to_rise & !s.measure_rl &
                        cfg_r.probe_timeout_enable; // see [R10]
  assign rate_evt = s.probe_pulse & !pulse_prev_r & !s.probe_decayed &
                    cfg_r.probe_rate_fault_enable; // see [R11]
  assign retry_evt = probe_to_evt | rate_evt;
  assign tickle_rise = s.watchdog_tickle & !tickle_prev_r;
  assign wdt_rise = wdt_expired & !wdt_prev_r & cfg_r.host_watchdog_enable;
  assign bus_live = cfg_r.bus_limit_enable & s.bus_over_limit; // see [R13]
  assign cur_sat_live = cfg_r.sat_flags_enable & s.cur_loop_sat; // see [R14]
  assign spd_sat_live = cfg_r.sat_flags_enable & s.spd_loop_sat; // see [R15]

  interval_timer #(
    .UNIT_CYCLES(PROBE_TIMEOUT_CYC)
  ) u_probe_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(!s.probe_ramp),
    .run(s.probe_ramp),
    .units(8'h01),
    .expired(probe_to)
  );

  interval_timer #(
    .UNIT_CYCLES(RETRY_UNIT_CYC)
  ) u_retry_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(retry_evt || (state_r != ST_RETRY)),
    .run(state_r == ST_RETRY),
    .units({4'h0, cfg_r.lock_retry_time}),
    .expired(retry_done)
  );

  // the clear command re-arms the watchdog as well
  interval_timer #(
    .UNIT_CYCLES(WDT_UNIT_CYC)
  ) u_wdt_timer (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .restart(tickle_rise || !cfg_r.host_watchdog_enable ||
             fault_clear_cmd_r),
    .run(cfg_r.host_watchdog_enable),
    .units(cfg_r.wdt_interval),
    .expired(wdt_expired)
  );

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_r <= ST_RESET;
    end else if (uv_any) begin
      state_r <= ST_RESET; // see [R1] see [R2]
    end else begin
      case (state_r)
        ST_RESET: begin
          state_r <= ST_RUN;
        end
        ST_RUN: begin
          if (retry_evt) begin
            state_r <= ST_RETRY; // see [R10] see [R11]
          end
        end
        ST_RETRY: begin
          if (retry_done && !retry_evt) begin
            state_r <= ST_RUN; // see [R17]
          end
        end
        default: begin
          state_r <= ST_RESET;
        end
      endcase
    end
  end

  // sticky supply flags: a set in the clear cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_low_flag_r <= 1'b0;
      ov_flag_r <= 1'b0;
      buck_flag_r <= 1'b0;
    end else if (uv_any) begin
      pump_low_flag_r <= 1'b0;
      ov_flag_r <= 1'b0;
      buck_flag_r <= 1'b0;
    end else begin
      if (s.pump_uv) begin
        pump_low_flag_r <= 1'b1; // see [R4]
      end else if (fault_clear_cmd_r) begin
        pump_low_flag_r <= 1'b0; // see [R5]
      end
      if (ov_live) begin
        ov_flag_r <= 1'b1; // see [R6]
      end else if (fault_clear_cmd_r) begin
        ov_flag_r <= 1'b0; // see [R7]
      end
      if (s.buck_uv) begin
        buck_flag_r <= 1'b1; // see [R3]
      end else if (fault_clear_cmd_r) begin
        buck_flag_r <= 1'b0;
      end
    end
  end

  // retry flags drop when the retry period runs out
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      probe_to_flag_r <= 1'b0;
      rate_flag_r <= 1'b0;
    end else if (uv_any) begin
      probe_to_flag_r <= 1'b0;
      rate_flag_r <= 1'b0;
    end else begin
      if (probe_to_evt) begin
        probe_to_flag_r <= 1'b1; // see [R10]
      end else if (state_r == ST_RETRY && retry_done) begin
        probe_to_flag_r <= 1'b0; // see [R17]
      end
      if (rate_evt) begin
        rate_flag_r <= 1'b1; // see [R11]
      end else if (state_r == ST_RETRY && retry_done) begin
        rate_flag_r <= 1'b0; // see [R17]
      end
    end
  end

  // latched faults need the condition gone and a clear command
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      meas_probe_r <= 1'b0;
      meas_bemf_r <= 1'b0;
      wdt_flag_r <= 1'b0;
      wdt_lock_r <= 1'b0;
    end else if (uv_any) begin
      meas_probe_r <= 1'b0;
      meas_bemf_r <= 1'b0;
      wdt_flag_r <= 1'b0;
      wdt_lock_r <= 1'b0;
    end else begin
      if (meas_probe_cond) begin
        meas_probe_r <= 1'b1; // see [R12]
      end else if (fault_clear_cmd_r) begin
        meas_probe_r <= 1'b0; // see [R18]
      end
      if (bemf_cond) begin
        meas_bemf_r <= 1'b1; // see [R12]
      end else if (fault_clear_cmd_r) begin
        meas_bemf_r <= 1'b0; // see [R18]
      end
      if (wdt_rise) begin
        wdt_flag_r <= 1'b1; // see [R16]
        wdt_lock_r <= cfg_r.host_watchdog_action_sel; // see [R16]
      end else if (fault_clear_cmd_r) begin
        wdt_flag_r <= 1'b0; // see [R18]
        wdt_lock_r <= 1'b0;
      end
    end
  end

  assign drv_fault = s.pump_uv | ov_live; // see [R4] see [R6]
  assign ctrl_fault = (state_r == ST_RETRY) | meas_probe_r | meas_bemf_r |
                      wdt_flag_r | bus_live | cur_sat_live | spd_sat_live;
  assign any_report = drv_fault | ctrl_fault; // see [R20]
  assign hiz = uv_any | (state_r == ST_RESET) | s.pump_uv | ov_live |
               (state_r == ST_RETRY) | meas_probe_r | meas_bemf_r |
               wdt_lock_r; // see [R4] see [R6] see [R12] see [R16]

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_out_n_r <= 1'b1;
      fets_off_r <= 1'b1;
      speed_limit_r <= 1'b0;
    end else begin
      fault_out_n_r <= uv_any | !any_report; // see [R20] see [R5] see [R7]
      fets_off_r <= hiz; // see [R17] see [R18]
      speed_limit_r <= bus_live; // see [R13]
    end
  end

  // the controller comes back two cycles after the supply recovers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      pump_enable_r <= 1'b0;
      ctrl_enable_r <= 1'b0;
      core_reset_r <= 1'b1;
    end else begin
      pump_enable_r <= !uv_any; // see [R1] see [R2]
      ctrl_enable_r <= !uv_any && (state_r != ST_RESET); // see [R1]
      core_reset_r <= uv_any || (state_r == ST_RESET); // see [R2]
    end
  end

  assign status = '{
    fault_pin_low: !fault_out_n_r,
    watchdog_fault: wdt_flag_r,
    spd_sat: spd_sat_live,
    cur_sat: cur_sat_live,
    bus_limit: bus_live,
    measure_backemf_fault: meas_bemf_r,
    measure_probe_fault: meas_probe_r,
    probe_rate_flag: rate_flag_r,
    probe_timeout_flag: probe_to_flag_r,
    buck_low_flag: buck_flag_r,
    supply_overvoltage_flag: ov_flag_r,
    pump_low_flag: pump_low_flag_r,
    controller_fault: ctrl_fault,
    driver_fault: drv_fault
  };

  // one wait state: pready rises in the second access cycle
  assign access = apb_req.psel & apb_req.penable;
  assign commit = access & rsp_r.pready;
  assign mapped = reg_hit(apb_req.paddr, ADDR_CTRL) |
                  reg_hit(apb_req.paddr, ADDR_CMD) |
                  reg_hit(apb_req.paddr, ADDR_STATUS);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rsp_r <= '0;
    end else begin
      rsp_r.pready <= access & !rsp_r.pready;
      if (access && !rsp_r.pready) begin
        rsp_r.pslverr <= !mapped;
        if (!apb_req.pwrite && reg_hit(apb_req.paddr, ADDR_CTRL)) begin
          rsp_r.prdata <= DATA_W'(cfg_r);
        end else if (!apb_req.pwrite &&
                     reg_hit(apb_req.paddr, ADDR_STATUS)) begin
          rsp_r.prdata <= DATA_W'(status);
        end else begin
          rsp_r.prdata <= '0;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_r <= CFG_RESET;
    end else if (uv_any) begin
      cfg_r <= CFG_RESET; // see [R1]
    end else if (commit && apb_req.pwrite &&
                 reg_hit(apb_req.paddr, ADDR_CTRL)) begin
      cfg_r <= apb_req.pwdata[CFG_W-1:0];
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      fault_clear_cmd_r <= 1'b0;
    end else begin
      fault_clear_cmd_r <= commit && apb_req.pwrite &&
                           reg_hit(apb_req.paddr, ADDR_CMD) &&
                           apb_req.pwdata[CMD_CLEAR_BIT]; // see [R18]
    end
  end

  assign apb_rsp = rsp_r;
  assign fault_out_n = fault_out_n_r;
  assign fets_off = fets_off_r;
  assign pump_enable = pump_enable_r;
  assign ctrl_enable = ctrl_enable_r;
  assign core_reset = core_reset_r;
  assign speed_limit = speed_limit_r;

  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_n);

  sequence uv_seen;
    s.supply_uv || s.avdd_uv;
  endsequence
  sequence in_reset;
    state_r == ST_RESET && core_reset_r && fets_off_r && !pump_enable_r;
  endsequence

  a_uv_full_reset: assert property (uv_seen |=> in_reset) // see [R1]
    else $error("undervoltage did not force reset state");
  a_pump_stage_off: assert property ( // see [R4]
    s.pump_uv && !uv_any |=> fets_off_r && !fault_out_n_r)
    else $error("pump low did not stop stage and pull pin");
  a_pump_flag_sticky: assert property ( // see [R5]
    pump_low_flag_r && !fault_clear_cmd_r && !uv_any |=> pump_low_flag_r)
    else $error("pump flag dropped without clear");
  a_ov_ignored: assert property ( // see [R8]
    !cfg_r.supply_overvoltage_enable && !ov_flag_r |=> !ov_flag_r)
    else $error("overvoltage acted while disabled");
  a_ov_flag_set: assert property ( // see [R6]
    ov_live && !uv_any |=> ov_flag_r && status.driver_fault || !ov_live)
    else $error("overvoltage flag not set");
  a_retry_entry: assert property ( // see [R10]
    state_r == ST_RUN && retry_evt && !uv_any
    |=> state_r == ST_RETRY ##1 fets_off_r)
    else $error("probe fault did not start retry");
  a_retry_release: assert property ( // see [R17]
    state_r == ST_RETRY && retry_done && !retry_evt && !uv_any
    |=> state_r == ST_RUN)
    else $error("retry did not end after retry time");
  a_latch_hold: assert property ( // see [R12]
    meas_bemf_r && !fault_clear_cmd_r && !uv_any |=> meas_bemf_r)
    else $error("latched fault cleared without command");
  a_wdt_latched: assert property ( // see [R16]
    wdt_lock_r && !uv_any |=> fets_off_r)
    else $error("watchdog latch left stage running");
  a_pin_follows: assert property ( // see [R20]
    any_report && !uv_any |=> !fault_out_n_r)
    else $error("fault pin released while report active");
  // bus limiting alone must leave the stage running
  a_bus_speed: assert property ( // see [R13]
    bus_live && !uv_any && state_r == ST_RUN && !s.pump_uv && !ov_live &&
    !meas_probe_r && !meas_bemf_r && !wdt_lock_r
    |=> speed_limit_r && !fets_off_r && !fault_out_n_r)
    else $error("bus limit did not restrict speed");
  a_apb_wait: assert property (
    access && !rsp_r.pready |=> rsp_r.pready ##1 !rsp_r.pready)
    else $error("apb ready not a one cycle answer");
endmodule // fault_manager

// *** src/fault_pkg.sv ***
package fault_pkg;

  localparam int unsigned CLK_HZ = 200_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;

  // probe ramp limit, retry time step and watchdog interval step
  localparam int unsigned PROBE_TIMEOUT_MS = 500;
  localparam int unsigned PROBE_TIMEOUT_CYCLES = PROBE_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned RETRY_UNIT_MS = 100;
  localparam int unsigned RETRY_UNIT_CYCLES = RETRY_UNIT_MS * CYC_PER_MS;
  localparam int unsigned WDT_UNIT_MS = 1;
  localparam int unsigned WDT_UNIT_CYCLES = WDT_UNIT_MS * CYC_PER_MS;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_CMD = 12'h004;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h008;
  localparam int CMD_CLEAR_BIT = 0;

  typedef struct packed {
    logic [7:0] wdt_interval;
    logic [3:0] lock_retry_time;
    logic host_watchdog_action_sel;
    logic host_watchdog_enable;
    logic sat_flags_enable;
    logic bus_limit_enable;
    logic probe_rate_fault_enable;
    logic probe_timeout_enable;
    logic supply_overvoltage_level_sel;
    logic supply_overvoltage_enable;
  } ctrl_cfg_t;

  localparam int CFG_W = $bits(ctrl_cfg_t);
  localparam ctrl_cfg_t CFG_RESET = 20'h0a401;

  typedef struct packed {
    logic supply_uv;
    logic avdd_uv;
    logic buck_uv;
    logic pump_uv;
    logic supply_ov_low_trip;
    logic supply_ov_high_trip;
    logic probe_ramp;
    logic probe_pulse;
    logic probe_decayed;
    logic measure_rl;
    logic measure_ke;
    logic backemf_low;
    logic bus_over_limit;
    logic cur_loop_sat;
    logic spd_loop_sat;
    logic watchdog_tickle;
  } sense_t;

  typedef struct packed {
    logic fault_pin_low;
    logic watchdog_fault;
    logic spd_sat;
    logic cur_sat;
    logic bus_limit;
    logic measure_backemf_fault;
    logic measure_probe_fault;
    logic probe_rate_flag;
    logic probe_timeout_flag;
    logic buck_low_flag;
    logic supply_overvoltage_flag;
    logic pump_low_flag;
    logic controller_fault;
    logic driver_fault;
  } status_t;

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [DATA_W-1:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef enum logic [2:0] {
    ST_RESET = 3'b001,
    ST_RUN = 3'b010,
    ST_RETRY = 3'b100
  } pwr_state_t;

endpackage

// *** src/interval_timer.sv ***
`timescale 1ns/1ps
// counts units of UNIT_CYCLES while run is high; expired holds until restart
module interval_timer #(
  parameter int unsigned UNIT_CYCLES = 1
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic restart,
  input wire logic run,
  input wire logic [7:0] units,
  output logic expired
);
  logic [31:0] cyc_r;
  logic [7:0] unit_r;
  logic expired_r;
  logic [7:0] target;
  logic [7:0] unit_inc;

  // zero units would wait 256 units, so it counts as one
  assign target = (units == 8'h00) ? 8'h01 : units;
  assign unit_inc = 8'(unit_r + 8'h01);
  assign expired = expired_r;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r <= 32'h0;
      unit_r <= 8'h00;
      expired_r <= 1'b0;
    end else if (restart) begin
      cyc_r <= 32'h0;
      unit_r <= 8'h00;
      expired_r <= 1'b0;
    end else if (run && !expired_r) begin
      if (cyc_r == 32'(UNIT_CYCLES - 1)) begin
        cyc_r <= 32'h0;
        unit_r <= unit_inc;
        if (unit_inc == target) begin
          expired_r <= 1'b1;
        end
      end else begin
        cyc_r <= 32'(cyc_r + 32'h1);
      end
    end
  end
endmodule // interval_timer

// *** bench/host_model.sv ***
`timescale 1ns/1ps
// host side of the watchdog: refreshes the watchdog while run is high
module host_model #(
  parameter int unsigned PERIOD = 20
) (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic run,
  output logic tickle
);
  int unsigned cnt_r;

  // a toggle gives one rising edge per two periods, well inside the interval;
  // dropping run starves the watchdog on purpose
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= 0;
      tickle <= 1'b0;
    end else if (run) begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      if (cnt_r == PERIOD - 1) begin
        tickle <= ~tickle;
      end
    end
  end
endmodule // host_model

// *** bench/fault_manager_tb.sv ***
`timescale 1ns/1ps
module fault_manager_tb;
  import fault_pkg::*;
  logic ref_clk;
  logic rst_n;
  apb_req_t req;
  apb_rsp_t rsp;
  sense_t sns;
  sense_t sense_w;
  logic wd_run;
  logic tickle;
  logic fault_out_n, fets_off, pump_enable, ctrl_enable, core_reset;
  logic speed_limit;
  int fails;
  int compares;
  logic [31:0] d;
  logic e;

  always #2.5 ref_clk = ~ref_clk;

  always_comb begin
    sense_w = sns;
    sense_w.watchdog_tickle = tickle;
  end

  fault_manager #(
    .PROBE_TIMEOUT_CYC(20),
    .RETRY_UNIT_CYC(10),
    .WDT_UNIT_CYC(10)
  ) dut (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .apb_req(req),
    .apb_rsp(rsp),
    .sense(sense_w),
    .fault_out_n(fault_out_n),
    .fets_off(fets_off),
    .pump_enable(pump_enable),
    .ctrl_enable(ctrl_enable),
    .core_reset(core_reset),
    .speed_limit(speed_limit)
  );

  host_model host (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .run(wd_run),
    .tickle(tickle)
  );

  task automatic wrap_up;
    $display("compares %0d fails %0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] ex,
                     input logic [31:0] got);
    compares++;
    if (got !== ex) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // request held until pready is sampled high at a rising edge
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    int n;
    n = 0;
    @(posedge ref_clk);
    req <= '{1'b1, 1'b0, wr, a, wd};
    @(posedge ref_clk);
    req.penable <= 1'b1;
    do begin
      @(posedge ref_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 50);
    rd = rsp.prdata;
    err = rsp.pslverr;
    if (n >= 50) chk("pready", 1, 0);
    req <= '0;
  endtask

  task automatic rdc(input logic [11:0] a, input logic [31:0] ex,
                     input logic ee);
    apb(1'b0, a, 32'h0, d, e);
    chk("rdata", ex, d);
    chk("pslverr", ee, e);
  endtask

  task automatic wrc(input logic [11:0] a, input logic [31:0] wd,
                     input logic ee);
    apb(1'b1, a, wd, d, e);
    chk("pslverr", ee, e);
  endtask

  // controller_fault is checked as the summary of the controller flags
  task automatic st(input logic [31:0] ex);
    apb(1'b0, ADDR_STATUS, 32'h0, d, e);
    chk("status", ex, d & ~32'h2);
    chk("controller_fault", {31'h0, |ex[12:5]}, {31'h0, d[1]});
  endtask

  task automatic outs(input logic [2:0] ex);
    chk("fets_pin_spd", ex, {fets_off, fault_out_n, speed_limit});
  endtask

  task automatic clear_all;
    wrc(ADDR_CMD, 32'h1, 1'b0);
    repeat (3) @(posedge ref_clk);
    #1;
    st(32'h0);
    outs(3'b010);
  endtask

  task automatic fcase(input logic [31:0] ctrl, input logic [15:0] s,
                       input int hold, input int post,
                       input logic [2:0] lo, input logic [31:0] ls,
                       input logic [2:0] ao, input logic [31:0] as);
    wrc(ADDR_CTRL, ctrl, 1'b0);
    @(posedge ref_clk);
    sns <= sense_t'(s);
    repeat (hold) @(posedge ref_clk);
    #1;
    outs(lo);
    st(ls);
    @(posedge ref_clk);
    sns <= '0;
    repeat (post) @(posedge ref_clk);
    #1;
    outs(ao);
    st(as);
    clear_all();
  endtask

  initial begin
    #250000;
    fails++;
    wrap_up();
  end

  initial begin
    ref_clk = 1'b0;
    rst_n = 1'b0;
    req = '0;
    sns = '0;
    wd_run = 1'b0;
    repeat (6) @(posedge ref_clk);
    #1;
    outs(3'b110);
    chk("reset_ctl", 3'b001,
        {pump_enable, ctrl_enable, core_reset});
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("run_ctl", 2'b10, {ctrl_enable, core_reset});
    outs(3'b010);
    rdc(ADDR_CTRL, 32'h0a401, 1'b0);
    st(32'h0);
    rdc(12'h00c, 32'h0, 1'b1);
    rdc(12'h002, 32'h0, 1'b1);
    wrc(12'h00c, 32'hffffffff, 1'b1);
    wrc(ADDR_STATUS, 32'hffffffff, 1'b0);
    rdc(ADDR_CTRL, 32'h0a401, 1'b0);
    rdc(ADDR_CMD, 32'h0, 1'b0);
    // ctrl, sense, hold, post, live outs, live status, after outs, status
    fcase(32'h0a401, 16'h1000, 4, 4, 3'b100, 32'h2005,
          3'b010, 32'h4);
    fcase(32'h0a401, 16'h0800, 4, 4, 3'b100, 32'h2009,
          3'b010, 32'h8);
    fcase(32'h0a403, 16'h0800, 4, 4, 3'b010, 32'h0,
          3'b010, 32'h0);
    fcase(32'h0a403, 16'h0c00, 4, 4, 3'b100, 32'h2009,
          3'b010, 32'h8);
    fcase(32'h0a400, 16'h0c00, 4, 4, 3'b010, 32'h0,
          3'b010, 32'h0);
    fcase(32'h0a401, 16'h2000, 4, 4, 3'b010, 32'h10,
          3'b010, 32'h10);
    fcase(32'h0a411, 16'h0008, 4, 4, 3'b001, 32'h2200,
          3'b010, 32'h0);
    fcase(32'h0a401, 16'h0008, 4, 4, 3'b010, 32'h0,
          3'b010, 32'h0);
    fcase(32'h0a421, 16'h0004, 4, 4, 3'b000, 32'h2400,
          3'b010, 32'h0);
    fcase(32'h0a421, 16'h0002, 4, 4, 3'b000, 32'h2800,
          3'b010, 32'h0);
    fcase(32'h0a401, 16'h0006, 4, 4, 3'b010, 32'h0,
          3'b010, 32'h0);
    fcase(32'h0a401, 16'h0030, 4, 4, 3'b100, 32'h2100,
          3'b100, 32'h2100);
    fcase(32'h0a401, 16'h0240, 30, 4, 3'b100, 32'h2080,
          3'b100, 32'h2080);
    fcase(32'h0a205, 16'h0200, 26, 30, 3'b100, 32'h2020,
          3'b010, 32'h0);
    fcase(32'h0a201, 16'h0200, 26, 30, 3'b010, 32'h0,
          3'b010, 32'h0);
    fcase(32'h0a209, 16'h0100, 6, 30, 3'b100, 32'h2040,
          3'b010, 32'h0);
    // pulse gone early: the stage stays off until the retry time is out
    fcase(32'h0a209, 16'h0100, 6, 6, 3'b100, 32'h2040,
          3'b100, 32'h2040);
    fcase(32'h0a209, 16'h0180, 6, 30, 3'b010, 32'h0,
          3'b010, 32'h0);
    // clear while the condition is still present must not end the fault
    @(posedge ref_clk);
    sns <= sense_t'(16'h0030);
    repeat (4) @(posedge ref_clk);
    wrc(ADDR_CMD, 32'h1, 1'b0);
    repeat (3) @(posedge ref_clk);
    st(32'h2100);
    @(posedge ref_clk);
    sns <= '0;
    clear_all();
    for (int m = 0; m < 2; m++) begin
      @(posedge ref_clk);
      wd_run <= 1'b1;
      wrc(ADDR_CTRL, 32'h0a441 | (m << 7), 1'b0);
      repeat (300) @(posedge ref_clk);
      st(32'h0);
      @(posedge ref_clk);
      wd_run <= 1'b0;
      repeat (150) @(posedge ref_clk);
      #1;
      outs({m[0], 2'b00});
      st(32'h3000);
      @(posedge ref_clk);
      wd_run <= 1'b1;
      clear_all();
    end
    wrc(ADDR_CTRL, 32'h0a401, 1'b0);
    @(posedge ref_clk);
    wd_run <= 1'b0;
    for (int i = 0; i < 2; i++) begin
      wrc(ADDR_CTRL, 32'h0a43d, 1'b0);
      @(posedge ref_clk);
      sns <= sense_t'(i == 0 ? 16'h8000 : 16'h4000);
      repeat (4) @(posedge ref_clk);
      #1;
      outs(3'b110);
      chk("uv_ctl", 3'b001,
          {pump_enable, ctrl_enable, core_reset});
      @(posedge ref_clk);
      sns <= '0;
      repeat (8) @(posedge ref_clk);
      #1;
      chk("uv_run", 2'b10, {ctrl_enable, core_reset});
      rdc(ADDR_CTRL, 32'h0a401, 1'b0);
    end
    wrc(ADDR_CTRL, 32'h0a403, 1'b0);
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdc(ADDR_CTRL, 32'h0a401, 1'b0);
    wrap_up();
  end
endmodule // fault_manager_tb
